// ==== src/serial_port.sv ====
`timescale 1ns/100ps
// What this block does
// [R1] Mode 1 frame: start, eight data bits LSB first, stop; ten bits.
// [R2] Mode 1 accepted frame puts the stop bit into ninth_rx_bit.
// [R3] Buffer write starts sending after the next divide-by-16 rollover.
// [R4] Mode 1 sets tx_done_flag two clocks after the stop bit ends.
// [R5] Mode 2 sets tx_done_flag as the stop bit is driven.
// [R6] With rx_enable, reception starts on a start-bit falling edge.
// [R7] Receive pin sampled sixteen times per bit at any baud rate.
// [R8] Start edge resets the receive divide-by-16 counter to align bits.
// [R9] Each bit is a majority of three mid-bit samples.
// [R10] Accept at mid stop only if flag clear and qualifier allows.
// [R11] After mid stop the receiver returns to idle watching for start.
// [R12] Timer 1 baud is overflow over 32, or 16 with baud doubling.
// [R13] Port 0 may use timer 1 or 2; port 1 only timer 1.
// [R14] Timer 1 auto-reload counts at osc/12 or osc/4, overflow per 256-reload.
// [R15] Timer 2 select bits give osc / (32 * (65536 - reload)) per direction.
// [R16] Timer 2 in baud use sets no flag and ignores external reload.
// [R17] Mode 2 frame adds ninth bit from ninth_tx_bit; eleven bits.
// [R18] Mode 2 reception stores ninth bit, ignores the stop bit.
// [R19] Mode 2 baud is osc/64, or osc/32 with doubling.
// [R20] Multiprocessor mode raises rx_done_flag only when ninth bit is one.
// [R21] Done flags stay set until software clears them.
// [R22] Remote station sends matching format and baud, idling high.
// [R23] Transmit pin idles high; start bit low, stop bit high.
module serial_port
  import serial_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Serial pins
  input  wire logic        rxd,
  output logic             txd,
  // Mode and baud configuration
  input  wire logic        mode2,
  input  wire logic        port_id,
  input  wire logic        port0_baud_double,
  input  wire logic        port1_baud_double,
  input  wire logic        timer1_fast_clock,
  input  wire logic [7:0]  timer1_reload,
  input  wire logic        timer2_tx_baud_sel,
  input  wire logic        timer2_rx_baud_sel,
  input  wire logic [15:0] timer2_reload_value,
  input  wire logic        timer2_ext_pin,
  // Receive control
  input  wire logic        rx_enable,
  input  wire logic        multiproc_enable,
  // Software access
  input  wire logic        serial_buffer_write,
  input  wire logic [7:0]  serial_buffer_wdata,
  input  wire logic        ninth_tx_bit,
  input  wire logic        tx_done_clear,
  input  wire logic        rx_done_clear,
  input  wire logic        timer2_flag_clear,
  // Status
  output logic [7:0]       serial_buffer,
  output logic             ninth_rx_bit,
  output logic             tx_done_flag,
  output logic             rx_done_flag,
  output logic             tx_busy,
  output logic             timer2_overflow_flag
);

  tick_if    ticks ();
  tx_state_t tx_state;
  rx_state_t rx_state;
  logic [3:0] tx_div;
  logic [9:0] tx_shift;
  logic [3:0] tx_left;
  logic [1:0] tx_delay;
  logic [7:0] rx_shift;
  logic [2:0] rx_count;
  logic       rx_ninth;
  logic       line_fall, bit_ready, bit_value;
  logic       baud_double, t2_tx, t2_rx;
  logic       tx_roll, tx_done_set, rx_restart, rx_qual, rx_accept, stop_mid;

  // Port 1 has no timer 2 path and its own doubling bit
  assign baud_double = port_id ? port1_baud_double : port0_baud_double; // R12
  assign t2_tx       = timer2_tx_baud_sel && !port_id; // R13
  assign t2_rx       = timer2_rx_baud_sel && !port_id; // R13

  baud_gen u_baud (
    .clock                (clock),
    .reset                (reset),
    .mode2                (mode2),
    .baud_double          (baud_double),
    .timer1_fast_clock    (timer1_fast_clock),
    .timer1_reload        (timer1_reload),
    .t2_tx_sel            (t2_tx),
    .t2_rx_sel            (t2_rx),
    .timer2_reload_value  (timer2_reload_value),
    .timer2_ext_pin       (timer2_ext_pin),
    .timer2_flag_clear    (timer2_flag_clear),
    .timer2_overflow_flag (timer2_overflow_flag),
    .ticks                (ticks.gen)
  );

  rx_sampler u_sampler (
    .clock     (clock),
    .reset     (reset),
    .rxd       (rxd),
    .rx_tick   (ticks.rx_tick),
    .restart   (rx_restart),
    .line_fall (line_fall),
    .bit_ready (bit_ready),
    .bit_value (bit_value)
  );

  // ---- Transmitter ----

  // Free-running transmit bit clock; its rollover paces every bit edge
  assign tx_roll = ticks.tx_tick && (tx_div == DIV_LAST);

  always_ff @(posedge clock) begin
    if (reset) begin
      tx_div <= 4'h0;
    end else if (ticks.tx_tick) begin
      tx_div <= tx_div + 4'h1;
    end
  end

  // Frame sequencer; a write while busy is dropped, software waits for the flag
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_state <= TX_IDLE;
      tx_shift <= 10'h3ff;
      tx_left  <= 4'h0;
      txd      <= 1'b1;
      tx_busy  <= 1'b0;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          txd <= 1'b1; // R23
          if (serial_buffer_write) begin
            tx_shift <= {1'b1, mode2 ? ninth_tx_bit : 1'b1, serial_buffer_wdata}; // R17
            tx_left  <= mode2 ? TX_BITS_MODE2 : TX_BITS_MODE1; // R1
            tx_state <= TX_WAIT;
            tx_busy  <= 1'b1;
          end
        end
        TX_WAIT: begin
          if (tx_roll) begin
            txd      <= 1'b0; // R3
            tx_state <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_roll) begin
            if (tx_left == 4'h0) begin
              txd      <= 1'b1;
              tx_state <= TX_IDLE;
              tx_busy  <= 1'b0;
            end else begin
              txd      <= tx_shift[0]; // R1
              tx_shift <= {1'b1, tx_shift[9:1]};
              tx_left  <= tx_left - 4'h1;
            end
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // Mode 1 done flag waits two clocks past the end of the stop bit
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_delay <= 2'h0;
    end else if (tx_state == TX_SEND && tx_roll && tx_left == 4'h0 && !mode2) begin
      tx_delay <= TX_DONE_DELAY; // R4
    end else if (tx_delay != 2'h0) begin
      tx_delay <= tx_delay - 2'h1;
    end
  end

  assign tx_done_set = (tx_delay == 2'h1) // R4
                       || (tx_state == TX_SEND && tx_roll && tx_left == 4'h1 && mode2); // R5

  // Sticky done flag; a set in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_done_flag <= 1'b0;
    end else begin
      tx_done_flag <= tx_done_set || (tx_done_flag && !tx_done_clear); // R21
    end
  end

  // ---- Receiver ----

  assign rx_restart = (rx_state == RX_IDLE) && rx_enable && line_fall; // R6
  assign stop_mid   = (rx_state == RX_STOP) && bit_ready;
  assign rx_qual    = mode2 ? rx_ninth : bit_value; // R20
  assign rx_accept  = stop_mid && !rx_done_flag && (!multiproc_enable || rx_qual); // R10

  // Receive sequencer; a high start bit is treated as noise and dropped
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_state <= RX_IDLE;
      rx_shift <= BUFFER_RESET;
      rx_count <= 3'h0;
      rx_ninth <= 1'b0;
    end else if (!rx_enable && rx_state != RX_IDLE) begin
      rx_state <= RX_IDLE;
    end else begin
      case (rx_state)
        RX_IDLE: begin
          if (rx_restart) begin
            rx_state <= RX_START; // R6
          end
        end
        RX_START: begin
          if (bit_ready) begin
            rx_count <= 3'h0;
            rx_state <= bit_value ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (bit_ready) begin
            rx_shift <= {bit_value, rx_shift[7:1]}; // R1
            rx_count <= rx_count + 3'h1;
            if (rx_count == RX_DATA_LAST) begin
              rx_state <= mode2 ? RX_NINTH : RX_STOP;
            end
          end
        end
        RX_NINTH: begin
          if (bit_ready) begin
            rx_ninth <= bit_value; // R18
            rx_state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (bit_ready) begin
            rx_state <= RX_IDLE; // R11
          end
        end
        default: begin
          rx_state <= RX_IDLE;
        end
      endcase
    end
  end

  // Accepted frame lands in the buffer; a rejected one leaves all untouched
  always_ff @(posedge clock) begin
    if (reset) begin
      serial_buffer <= BUFFER_RESET;
      ninth_rx_bit  <= 1'b0;
    end else if (rx_accept) begin
      serial_buffer <= rx_shift; // R10
      ninth_rx_bit  <= mode2 ? rx_ninth : bit_value; // R2
    end
  end

  // Sticky receive flag; a set in the clearing cycle wins
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_done_flag <= 1'b0;
    end else begin
      rx_done_flag <= rx_accept || (rx_done_flag && !rx_done_clear); // R21
    end
  end

  // ---- Checks ----

  sequence s_m1_stop_end;
    tx_state == TX_SEND && tx_roll && tx_left == 4'h0 && !mode2;
  endsequence

  sequence s_m2_stop_drive;
    tx_state == TX_SEND && tx_roll && tx_left == 4'h1 && mode2;
  endsequence

  property p_tx_idle_high;
    @(posedge clock) disable iff (reset)
      (tx_state == TX_IDLE && $past(tx_state) == TX_IDLE) |-> txd;
  endproperty
  a_tx_idle_high: assert property (p_tx_idle_high) // R23
    else $error("transmit pin not high while idle");

  property p_tx_start;
    @(posedge clock) disable iff (reset)
      (tx_state == TX_WAIT && tx_roll) |=> (!txd && tx_state == TX_SEND);
  endproperty
  a_tx_start: assert property (p_tx_start) // R3
    else $error("start bit not driven at rollover");

  property p_tx_wait_holds;
    @(posedge clock) disable iff (reset)
      (tx_state == TX_WAIT && !tx_roll) |=> (txd && tx_state == TX_WAIT);
  endproperty
  a_tx_wait_holds: assert property (p_tx_wait_holds) // R3
    else $error("start bit driven before rollover");

  property p_m1_done;
    @(posedge clock) disable iff (reset)
      s_m1_stop_end |-> ##1 !tx_done_set ##1 tx_done_set ##1 tx_done_flag;
  endproperty
  a_m1_done: assert property (p_m1_done) // R4
    else $error("mode 1 done flag not two clocks after stop");

  property p_m2_done;
    @(posedge clock) disable iff (reset)
      s_m2_stop_drive |=> (txd && tx_done_flag);
  endproperty
  a_m2_done: assert property (p_m2_done) // R5
    else $error("mode 2 done flag not set with stop bit");

  property p_rx_begin;
    @(posedge clock) disable iff (reset)
      rx_restart |=> rx_state == RX_START;
  endproperty
  a_rx_begin: assert property (p_rx_begin) // R6
    else $error("receiver missed start edge");

  property p_rx_accept;
    @(posedge clock) disable iff (reset)
      rx_accept |=> (rx_done_flag && serial_buffer == $past(rx_shift));
  endproperty
  a_rx_accept: assert property (p_rx_accept) // R10
    else $error("accepted frame not stored");

  property p_rx_reject;
    @(posedge clock) disable iff (reset)
      (stop_mid && !rx_done_flag && multiproc_enable && !rx_qual) |=> !rx_done_flag;
  endproperty
  a_rx_reject: assert property (p_rx_reject) // R20
    else $error("non-address frame raised receive flag");

  property p_rx_idle_after;
    @(posedge clock) disable iff (reset)
      stop_mid |=> rx_state == RX_IDLE;
  endproperty
  a_rx_idle_after: assert property (p_rx_idle_after) // R11
    else $error("receiver not idle after stop");

  property p_flags_sticky;
    @(posedge clock) disable iff (reset)
      (tx_done_flag && !tx_done_clear) || (rx_done_flag && !rx_done_clear)
        |=> (tx_done_flag || $past(tx_done_clear) || !$past(tx_done_flag))
         && (rx_done_flag || $past(rx_done_clear) || !$past(rx_done_flag));
  endproperty
  a_flags_sticky: assert property (p_flags_sticky) // R21
    else $error("done flag dropped without clear");

endmodule // serial_port

// ==== src/serial_pkg.sv ====
package serial_pkg;

  // Bit timing: sixteen receive samples per bit, vote on the middle three
  localparam logic [3:0] DIV_LAST       = 4'hf;
  localparam logic [3:0] VOTE_FIRST     = 4'h7;
  localparam logic [3:0] VOTE_LAST      = 4'h9;

  // Bits shifted out after the start bit: 8 data + stop, or 8 data + ninth + stop
  localparam logic [3:0] TX_BITS_MODE1  = 4'h9;
  localparam logic [3:0] TX_BITS_MODE2  = 4'ha;
  localparam logic [2:0] RX_DATA_LAST   = 3'h7;

  // Oscillator prescale for timer 1: divide by 12, or by 4 in fast mode
  localparam logic [3:0] T1_PRE_SLOW    = 4'hb;
  localparam logic [3:0] T1_PRE_FAST    = 4'h3;

  // Mode 2 oversample tick: osc/64 baud needs a tick every 4 clocks, osc/32 every 2
  localparam logic [1:0] M2_TICK_SLOW   = 2'h3;
  localparam logic [1:0] M2_TICK_FAST   = 2'h1;

  // Mode 1 transmit-done delay after the stop bit ends, in clock cycles
  localparam logic [1:0] TX_DONE_DELAY  = 2'h2;

  // Values after reset
  localparam logic [7:0]  TIMER1_RESET  = 8'h00;
  localparam logic [15:0] TIMER2_RESET  = 16'h0000;
  localparam logic [7:0]  BUFFER_RESET  = 8'h00;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} rx_state_t;
  typedef enum {TX_IDLE, TX_WAIT, TX_SEND} tx_state_t;

endpackage

// ==== src/tick_if.sv ====
`timescale 1ns/100ps
interface tick_if;
  logic tx_tick;
  logic rx_tick;
  modport gen  (output tx_tick, output rx_tick);
  modport user (input tx_tick, input rx_tick);
endinterface // tick_if

// ==== src/baud_gen.sv ====
`timescale 1ns/100ps
module baud_gen
  import serial_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // Configuration
  input  wire logic        mode2,
  input  wire logic        baud_double,
  input  wire logic        timer1_fast_clock,
  input  wire logic [7:0]  timer1_reload,
  input  wire logic        t2_tx_sel,
  input  wire logic        t2_rx_sel,
  input  wire logic [15:0] timer2_reload_value,
  input  wire logic        timer2_ext_pin,
  input  wire logic        timer2_flag_clear,
  output logic             timer2_overflow_flag,
  // Oversample ticks
  tick_if.gen              ticks
);

  logic [3:0]  t1_pre;
  logic [7:0]  timer1;
  logic        t1_ovf;
  logic        t1_half;
  logic        t2_pre;
  logic [15:0] timer2;
  logic        t2_ovf;
  logic [1:0]  m2_cnt;
  logic        ext_s1, ext_s2, ext_s3, ext_level;
  logic        t1_inc, t1_tick, m2_tick, ext_fall, t2_baud;

  assign t1_inc   = (t1_pre == (timer1_fast_clock ? T1_PRE_FAST : T1_PRE_SLOW));
  assign t1_tick  = t1_ovf && (baud_double || t1_half); // R12
  assign m2_tick  = (m2_cnt == (baud_double ? M2_TICK_FAST : M2_TICK_SLOW));
  assign ext_fall = ext_level && (ext_s2 == ext_s3) && !ext_s2;
  assign t2_baud  = t2_tx_sel || t2_rx_sel;

  // Timer 1 in 8-bit auto-reload, counting at osc/12 or osc/4
  always_ff @(posedge clock) begin
    if (reset) begin
      t1_pre <= 4'h0;
      timer1 <= TIMER1_RESET;
      t1_ovf <= 1'b0;
    end else begin
      t1_pre <= t1_inc ? 4'h0 : t1_pre + 4'h1; // R14
      t1_ovf <= t1_inc && (timer1 == 8'hff);
      if (t1_inc) begin
        timer1 <= (timer1 == 8'hff) ? timer1_reload : timer1 + 8'h01; // R14
      end
    end
  end

  // Halve the overflow rate unless the baud rate is doubled
  always_ff @(posedge clock) begin
    if (reset) begin
      t1_half <= 1'b0;
    end else if (t1_ovf) begin
      t1_half <= ~t1_half;
    end
  end

  // External reload pin: three stages, a change counts when the last two agree
  always_ff @(posedge clock) begin
    if (reset) begin
      ext_s1    <= 1'b1;
      ext_s2    <= 1'b1;
      ext_s3    <= 1'b1;
      ext_level <= 1'b1;
    end else begin
      ext_s1 <= timer2_ext_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (ext_s2 == ext_s3) begin
        ext_level <= ext_s2;
      end
    end
  end

  // Timer 2 counts at osc/2 with 16-bit auto-reload
  always_ff @(posedge clock) begin
    if (reset) begin
      t2_pre <= 1'b0;
      timer2 <= TIMER2_RESET;
      t2_ovf <= 1'b0;
    end else begin
      t2_pre <= ~t2_pre;
      t2_ovf <= t2_pre && (timer2 == 16'hffff); // R15
      if (t2_pre && timer2 == 16'hffff) begin
        timer2 <= timer2_reload_value;
      end else if (ext_fall && !t2_baud) begin
        timer2 <= timer2_reload_value; // R16
      end else if (t2_pre) begin
        timer2 <= timer2 + 16'h0001;
      end
    end
  end

  // Overflow flag is silent while timer 2 serves the port; set beats clear
  always_ff @(posedge clock) begin
    if (reset) begin
      timer2_overflow_flag <= 1'b0;
    end else begin
      timer2_overflow_flag <= (t2_ovf && !t2_baud) // R16
                              || (timer2_overflow_flag && !timer2_flag_clear);
    end
  end

  // Fixed mode 2 divider and tick selection per direction
  always_ff @(posedge clock) begin
    if (reset) begin
      m2_cnt        <= 2'h0;
      ticks.tx_tick <= 1'b0;
      ticks.rx_tick <= 1'b0;
    end else begin
      m2_cnt        <= m2_tick ? 2'h0 : m2_cnt + 2'h1; // R19
      ticks.tx_tick <= mode2 ? m2_tick : (t2_tx_sel ? t2_ovf : t1_tick); // R15
      ticks.rx_tick <= mode2 ? m2_tick : (t2_rx_sel ? t2_ovf : t1_tick); // R15
    end
  end

  property p_t2_flag_quiet;
    @(posedge clock) disable iff (reset)
      (t2_baud && !timer2_overflow_flag) |=> !timer2_overflow_flag;
  endproperty
  a_t2_flag_quiet: assert property (p_t2_flag_quiet) // R16
    else $error("timer 2 flag set while it drives the baud rate");

  property p_m2_spacing;
    @(posedge clock) disable iff (reset)
      (mode2 && !baud_double && $past(mode2) && !$past(baud_double) && ticks.tx_tick)[*1]
        ##1 (mode2 && !baud_double)[*3]
        |-> !$past(ticks.tx_tick) && !ticks.tx_tick;
  endproperty
  a_m2_spacing: assert property (p_m2_spacing) // R19
    else $error("mode 2 oversample tick spacing wrong");

endmodule // baud_gen

// ==== src/rx_sampler.sv ====
`timescale 1ns/100ps
module rx_sampler
  import serial_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Receive pin and timing
  input  wire logic rxd,
  input  wire logic rx_tick,
  input  wire logic restart,
  // Decisions
  output logic      line_fall,
  output logic      bit_ready,
  output logic      bit_value
);

  logic       s1, s2, s3, level;
  logic [3:0] cnt;
  logic [1:0] votes;
  logic       in_window;

  assign in_window = rx_tick && (cnt >= VOTE_FIRST) && (cnt <= VOTE_LAST);

  // Pin synchroniser and filtered level; the first stage feeds only the second
  always_ff @(posedge clock) begin
    if (reset) begin
      s1        <= 1'b1;
      s2        <= 1'b1;
      s3        <= 1'b1;
      level     <= 1'b1;
      line_fall <= 1'b0;
    end else begin
      s1        <= rxd;
      s2        <= s1;
      s3        <= s2;
      if (s2 == s3) begin
        level <= s2;
      end
      line_fall <= level && (s2 == s3) && !s2; // R6
    end
  end

  // Divide-by-16 sample counter, zeroed on the start edge
  always_ff @(posedge clock) begin
    if (reset) begin
      cnt <= 4'h0;
    end else if (restart) begin
      cnt <= 4'h0; // R8
    end else if (rx_tick) begin
      cnt <= cnt + 4'h1; // R7
    end
  end

  // Majority of three mid-bit samples; a single glitch cannot flip the bit
  always_ff @(posedge clock) begin
    if (reset) begin
      votes     <= 2'h0;
      bit_ready <= 1'b0;
      bit_value <= 1'b1;
    end else begin
      bit_ready <= in_window && (cnt == VOTE_LAST);
      if (in_window) begin
        votes <= {votes[0], level};
      end
      if (in_window && cnt == VOTE_LAST) begin
        bit_value <= (votes[1] & votes[0]) | (votes[1] & level) | (votes[0] & level); // R9
      end
    end
  end

  property p_restart_zero;
    @(posedge clock) disable iff (reset)
      restart |=> (cnt == 4'h0);
  endproperty
  a_restart_zero: assert property (p_restart_zero) // R8
    else $error("sample counter not cleared on start edge");

  property p_vote_time;
    @(posedge clock) disable iff (reset)
      (rx_tick && cnt == VOTE_LAST && !restart) |=> bit_ready;
  endproperty
  a_vote_time: assert property (p_vote_time) // R9
    else $error("bit decision missing after third vote");

endmodule // rx_sampler

// ==== test/remote_station.sv ====
`timescale 1ns/100ps
module remote_station (
  // Clock
  input  wire logic       clock,
  // Line settings shared with the port
  input  wire logic [7:0] bit_len,
  input  wire logic       ninth_used,
  // Serial pins seen from the far side
  input  wire logic       txd,
  output logic            rxd
);
  logic [10:0] frame;  // Last frame heard, start bit at index 0

  initial rxd = 1'b1;

  // Send one whole frame; the line is left high so it idles between frames
  task automatic send(input logic [8:0] value);
    logic [10:0] bits;
    bits = ninth_used ? {1'b1, value, 1'b0} : {2'b11, value[7:0], 1'b0};
    @(posedge clock);
    #1;
    for (int i = 0; i < (ninth_used ? 11 : 10); i++) begin
      rxd = bits[i];
      repeat (bit_len) @(posedge clock);
      #1;
    end
  endtask

  // Sample each transmitted bit at its middle; stop early so the next start is seen
  always begin
    @(negedge txd);
    repeat (bit_len / 2) @(posedge clock);
    for (int i = 0; i < (ninth_used ? 11 : 10); i++) begin
      frame[i] = txd;
      if (i < (ninth_used ? 10 : 9)) repeat (bit_len) @(posedge clock);
    end
  end
endmodule // remote_station

// ==== test/tb_async_serial_port_modes12.sv ====
`timescale 1ns/100ps
module tb_async_serial_port_modes12;
  import serial_pkg::*;
  logic        clock, reset, rxd, txd, mode2, port_id, dbl, t2, p0_dbl, p1_dbl;
  logic        rx_enable, multiproc_enable, wr, ninth_tx_bit, clr;
  logic        ninth_rx_bit, tx_done_flag, rx_done_flag, tx_busy, t2_flag;
  logic [7:0]  wdata, serial_buffer, bit_len;
  logic [8:0]  data, keep;
  logic        ext_pin;
  logic [7:0]  t1_reload;
  logic [15:0] t2_reload;
  int          mismatches, n_tests;
  // Mode 2, port id, doubling, timer 2 select
  localparam logic [3:0] CFG [6] = '{4'h2, 4'h0, 4'h1, 4'h7, 4'h8, 4'ha};

  serial_port i_dut (.clock(clock), .reset(reset), .rxd(rxd), .txd(txd), .mode2(mode2),
    .port_id(port_id), .port0_baud_double(p0_dbl), .port1_baud_double(p1_dbl),
    .timer1_fast_clock(1'b1), .timer1_reload(t1_reload), .timer2_tx_baud_sel(t2),
    .timer2_rx_baud_sel(t2), .timer2_reload_value(t2_reload), .timer2_ext_pin(ext_pin),
    .rx_enable(rx_enable), .multiproc_enable(multiproc_enable), .serial_buffer_write(wr),
    .serial_buffer_wdata(wdata), .ninth_tx_bit(ninth_tx_bit), .tx_done_clear(clr),
    .rx_done_clear(clr), .timer2_flag_clear(clr), .serial_buffer(serial_buffer),
    .ninth_rx_bit(ninth_rx_bit), .tx_done_flag(tx_done_flag), .rx_done_flag(rx_done_flag),
    .tx_busy(tx_busy), .timer2_overflow_flag(t2_flag));
  remote_station i_remote (.clock(clock), .bit_len(bit_len), .ninth_used(mode2),
    .txd(txd), .rxd(rxd));

  always #12.5 clock = ~clock;

  // Clocks per bit: timer 1 overflows every 4 clocks here, timer 2 every 2
  function automatic logic [7:0] bit_len_of(input logic [3:0] c);
    if (c[3]) return c[1] ? 8'h20 : 8'h40;
    if (c[0] && !c[2]) return 8'h20;
    return c[1] ? 8'h40 : 8'h80;
  endfunction

  task automatic check(input logic [10:0] seen, input logic [10:0] want);
    n_tests++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, want);
    end
  endtask

  // Pulse all clear strobes for one cycle
  task automatic clear_flags;
    @(posedge clock);
    #1 clr = 1'b1;
    @(posedge clock);
    #1 clr = 1'b0;
  endtask

  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Hang guard, well beyond the longest expected run
  initial begin
    #1250000;
    mismatches++;
    stop_test();
  end

  initial begin
    {clock, mode2, port_id, dbl, t2, multiproc_enable, wr, ninth_tx_bit, clr} = '0;
    {ext_pin, t1_reload, t2_reload} = {1'b1, 8'hff, 16'hffff};
    {reset, rx_enable, wdata, mismatches, n_tests} = {2'b11, 8'h00, 64'h0};
    void'($urandom(5));
    repeat (2) @(posedge clock);
    #1 reset = 1'b0;
    check({txd, tx_done_flag, rx_done_flag, tx_busy, t2_flag, ninth_rx_bit}, 11'h20);
    check(serial_buffer, 11'h000);
    // Pulse the reload pin so timer 2 starts from its reload, not from zero
    ext_pin = 1'b0;
    repeat (4) @(posedge clock);
    #1 ext_pin = 1'b1;
    foreach (CFG[k]) begin
      {mode2, port_id, dbl, t2} = CFG[k];
      {p0_dbl, p1_dbl} = {dbl ^ port_id, dbl ^ ~port_id};
      bit_len = bit_len_of(CFG[k]);
      data = 9'($urandom);
      @(posedge clock);
      #1 {wr, ninth_tx_bit, wdata} = {1'b1, data};
      @(posedge clock);
      #1 wr = 1'b0;
      check(tx_busy, 11'h001);
      for (int n = 0; n < 4000 && tx_done_flag !== 1'b1; n++) begin
        @(posedge clock);
        #1;
      end
      check(txd, 11'h001);
      repeat (bit_len) @(posedge clock);
      check({mode2 ? i_remote.frame[10] : 1'b1, i_remote.frame[9:0]},
            {2'b11, data[7:0], 1'b0} & ~{1'b0, !(mode2 ? data[8] : 1'b1), 9'h0});
      check(tx_done_flag, 11'h001);
      clear_flags();
      data = 9'($urandom);
      i_remote.send(data);
      check({rx_done_flag, ninth_rx_bit, serial_buffer},
            {2'b11, data[7:0]} & ~{1'b0, !(mode2 ? data[8] : 1'b1), 8'h0});
      check(t2_flag, {10'h000, !(t2 && !port_id)});
      clear_flags();
    end
    // Flag still set: a second frame is thrown away
    keep = {1'b1, 8'($urandom)};
    i_remote.send(keep);
    i_remote.send(9'h0c3);
    check({rx_done_flag, serial_buffer}, {1'b1, keep[7:0]});
    clear_flags();
    // Address filtering: data byte dropped, address byte taken
    multiproc_enable = 1'b1;
    i_remote.send(9'h05a);
    check({rx_done_flag, serial_buffer}, {1'b0, keep[7:0]});
    i_remote.send(9'h1a5);
    check({rx_done_flag, ninth_rx_bit, serial_buffer}, 10'h3a5);
    clear_flags();
    // Receiver disabled: nothing is taken
    rx_enable = 1'b0;
    i_remote.send(9'h1ff);
    check({rx_done_flag, serial_buffer}, 9'h0a5);
    stop_test();
  end
endmodule // tb_async_serial_port_modes12
